// ### design/dos_top.sv
// Purpose: Delayed one-shot pulse, two cascaded one-shot counters
// Assumes: Pins synchronous to clk; subclock and slow oscillator
//          arrive as sampled levels
// Notes:   Register port reads answer one cycle after the strobe
//
// Summary of operation
// RULE_01: Software sets both counters one-shot, second pulsing.
// RULE_02: Reference setup: 1 ms delay, 50 us pulse.
// RULE_03: First counter arms on trigger-select and start flag.
// RULE_04: Armed first counter starts on chosen pin edge.
// RULE_05: First counter at zero reloads, stops, requests.
// RULE_06: First underflow starts second when routed.
// RULE_07: Pulse pin goes high when second starts.
// RULE_08: Second at zero: pin low, reload, stop, request.
// RULE_09: Polarity bit inverts the second pulse pin.
// RULE_10: Extended bit 0: two mode bits pick clock.
// RULE_11: Extended bit 1: three field bits pick clock.
// RULE_12: First field bits 3:0, second bits 7:4.
// RULE_13: Base clock undivided or halved by prescaler bit.
// RULE_14: Routing bits 7:6 at 00 select trigger pin.
// RULE_15: Routing bits 1:0 at 10 chain first underflow.
// RULE_16: Trigger-select bit takes routed trigger source.
// RULE_17: Edge select ignored for chained trigger.
// RULE_18: Software writes reserved mode bit as zero.
// RULE_19: Pulse function bit makes pin a pulse output.
// RULE_20: Software sets trigger pin direction to input.
// RULE_21: Stopped counter idles at inactive output level.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module dos_top #(
    parameter int CW = dos_pkg::CW
) (
    input  wire logic                   clk,
    input  wire logic                   nrst,
    input  wire logic [dos_pkg::AW-1:0] addr,
    input  wire logic [dos_pkg::DW-1:0] wdata,
    input  wire logic                   wr,
    input  wire logic                   rd,
    output logic      [dos_pkg::DW-1:0] rdata,
    input  wire logic                   first_counter_trigger_pin,
    input  wire logic                   second_counter_trigger_pin,
    input  wire logic                   subclock_in,
    input  wire logic                   low_speed_osc_in,
    output logic                        first_counter_pulse_pin,
    output logic                        second_counter_pulse_pin
);
    logic [7:0]            one_shot_start;
    logic [7:0]            trig_routing;
    logic [7:0]            mode [2];
    logic [7:0]            clock_select;
    logic [7:0]            out_polarity;
    logic [7:0]            periph_clock;
    logic [1:0]            irq;

    logic [5:0]            pre;
    logic [4:0]            sub_cnt;
    logic                  sub_prev;
    logic                  loco_prev;
    logic [dos_pkg::T_N-1:0] ticks;

    logic [1:0]            pin_prev;
    logic [1:0]            pin_now;
    logic [1:0]            edge_hit;
    logic [1:0]            armed;
    logic [1:0]            sw_start;
    logic [1:0]            trig;
    logic [1:0]            tick;
    logic [1:0]            run;
    logic [1:0]            uf;
    logic [1:0]            pin;
    logic [CW-1:0]         cnt [2];
    logic [CW-1:0]         rld [2];

    // Address decode helpers
    function automatic logic hit(input logic [dos_pkg::AW-1:0] a);
        hit = wr && (addr == a);
    endfunction

    function automatic logic [dos_pkg::AW-1:0] value_addr(input int i);
        value_addr = (i == 0) ? dos_pkg::FIRST_VALUE : dos_pkg::SECOND_VALUE;
    endfunction

    function automatic logic [dos_pkg::AW-1:0] mode_addr(input int i);
        mode_addr = (i == 0) ? dos_pkg::FIRST_MODE : dos_pkg::SECOND_MODE;
    endfunction

    // Count source choice for one counter
    function automatic logic pick_tick(
        input logic [dos_pkg::CS_W-1:0] cs,
        input logic [1:0]               legacy,
        input logic [dos_pkg::T_N-1:0]  t
    );
        pick_tick = 1'b0;
        if (!cs[dos_pkg::EXT_BIT]) begin
            case (legacy) // [RULE_10]
                dos_pkg::LG_BASE:  pick_tick = t[dos_pkg::T_BASE];
                dos_pkg::LG_DIV8:  pick_tick = t[dos_pkg::T_D8];
                dos_pkg::LG_DIV32: pick_tick = t[dos_pkg::T_D32];
                dos_pkg::LG_SUB:   pick_tick = t[dos_pkg::T_SUB];
                default:           pick_tick = 1'b0;
            endcase
        end else begin
            case (cs[2:0]) // [RULE_11]
                dos_pkg::CS_BASE:  pick_tick = t[dos_pkg::T_BASE];
                dos_pkg::CS_DIV8:  pick_tick = t[dos_pkg::T_D8];
                dos_pkg::CS_DIV32: pick_tick = t[dos_pkg::T_D32];
                dos_pkg::CS_DIV64: pick_tick = t[dos_pkg::T_D64];
                dos_pkg::CS_LOCO:  pick_tick = t[dos_pkg::T_LOCO];
                dos_pkg::CS_SUB:   pick_tick = t[dos_pkg::T_SUB];
                default:           pick_tick = 1'b0;
            endcase
        end
    endfunction

    // Control registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            one_shot_start <= dos_pkg::REG_RESET;
        end else if (hit(dos_pkg::ONE_SHOT_START)) begin
            one_shot_start <= wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            trig_routing <= dos_pkg::REG_RESET;
        end else if (hit(dos_pkg::TRIG_ROUTING)) begin
            trig_routing <= wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            clock_select <= dos_pkg::REG_RESET;
        end else if (hit(dos_pkg::CLOCK_SELECT)) begin
            clock_select <= wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_polarity <= dos_pkg::REG_RESET;
        end else if (hit(dos_pkg::OUT_POLARITY)) begin
            out_polarity <= wdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            periph_clock <= dos_pkg::REG_RESET;
        end else if (hit(dos_pkg::PERIPH_CLOCK)) begin
            periph_clock <= wdata[7:0];
        end
    end

    // Prescaler and sampled slow clocks
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pre <= '0;
        end else begin
            pre <= pre + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sub_prev  <= 1'b0;
            loco_prev <= 1'b0;
        end else begin
            sub_prev  <= subclock_in;
            loco_prev <= low_speed_osc_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sub_cnt <= '0;
        end else if (subclock_in && !sub_prev) begin
            sub_cnt <= sub_cnt + 5'h01;
        end
    end

    always_comb begin
        ticks = '0;
        ticks[dos_pkg::T_BASE] = periph_clock[dos_pkg::HALVE_BIT] || pre[0]; // [RULE_13]
        ticks[dos_pkg::T_D8]   = (pre[2:0] == dos_pkg::D8_LAST[2:0]);
        ticks[dos_pkg::T_D32]  = (pre[4:0] == dos_pkg::D32_LAST[4:0]);
        ticks[dos_pkg::T_D64]  = (pre == dos_pkg::D64_LAST);
        ticks[dos_pkg::T_LOCO] = low_speed_osc_in && !loco_prev;
        ticks[dos_pkg::T_SUB]  = subclock_in && !sub_prev && (sub_cnt == dos_pkg::SUB_LAST);
    end

    // Trigger pin edge detection
    assign pin_now = {second_counter_trigger_pin, first_counter_trigger_pin};

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_prev <= '0;
        end else begin
            pin_prev <= pin_now;
        end
    end

    // Trigger selection per counter
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            edge_hit[i] = mode[i][dos_pkg::EDGE_BIT]
                        ? (pin_now[i] && !pin_prev[i])
                        : (!pin_now[i] && pin_prev[i]); // [RULE_04]
            armed[i] = mode[i][dos_pkg::TRIG_SEL_BIT]
                     && one_shot_start[dos_pkg::START_LSB + i]; // [RULE_03]
            sw_start[i] = hit(dos_pkg::ONE_SHOT_START)
                        && wdata[dos_pkg::START_LSB + i];
        end
        // Routed source only with trigger-select set
        if (mode[0][dos_pkg::TRIG_SEL_BIT]) begin // [RULE_16]
            trig[0] = armed[0] && edge_hit[0]
                    && (trig_routing[dos_pkg::FIRST_ROUTE_LSB +: 2]
                        == dos_pkg::ROUTE_PIN); // [RULE_14]
        end else begin
            trig[0] = sw_start[0];
        end
        if (mode[1][dos_pkg::TRIG_SEL_BIT]) begin // [RULE_16]
            case (trig_routing[dos_pkg::SECOND_ROUTE_LSB +: 2])
                dos_pkg::ROUTE_CHAIN: trig[1] = armed[1] && uf[0]; // [RULE_06] [RULE_15] [RULE_17]
                dos_pkg::ROUTE_PIN:   trig[1] = armed[1] && edge_hit[1];
                default:              trig[1] = 1'b0;
            endcase
        end else begin
            trig[1] = sw_start[1];
        end
    end

    // Two counter channels
    for (genvar g = 0; g < 2; g++) begin : g_chan
        always_ff @(posedge clk) begin
            if (!nrst) begin
                mode[g] <= dos_pkg::REG_RESET;
            end else if (hit(mode_addr(g))) begin
                mode[g] <= wdata[7:0];
            end
        end

        assign tick[g] = pick_tick(clock_select[g*dos_pkg::CS_W +: dos_pkg::CS_W],
                                   mode[g][dos_pkg::LEGACY_LSB +: 2], ticks); // [RULE_12]

        dos_chan #(
            .CW (CW)
        ) u_chan (
            .clk       (clk),
            .nrst      (nrst),
            .tick      (tick[g]),
            .trig      (trig[g]),
            .enable    (mode[g][dos_pkg::MODE_LSB +: 2] == dos_pkg::MODE_ONE_SHOT),
            .load      (hit(value_addr(g))),
            .load_data (wdata[CW-1:0]),
            .pulse_en  (mode[g][dos_pkg::PULSE_BIT]), // [RULE_19]
            .pol_inv   (out_polarity[g]),
            .count     (cnt[g]),
            .reload    (rld[g]),
            .running   (run[g]),
            .underflow (uf[g]),
            .pin       (pin[g])
        );

        // Request bit: set wins over write-one clear
        always_ff @(posedge clk) begin
            if (!nrst) begin
                irq[g] <= 1'b0;
            end else if (uf[g]) begin
                irq[g] <= 1'b1; // [RULE_05] [RULE_08]
            end else if (hit(dos_pkg::IRQ_STATUS) && wdata[g]) begin
                irq[g] <= 1'b0;
            end
        end
    end

    assign first_counter_pulse_pin  = pin[0];
    assign second_counter_pulse_pin = pin[1];

    // Read port, data valid only the cycle after rd
    always_ff @(posedge clk) begin
        if (!nrst || !rd) begin
            rdata <= '0;
        end else begin
            case (addr)
                dos_pkg::ONE_SHOT_START: rdata <= {8'h00, one_shot_start};
                dos_pkg::TRIG_ROUTING:   rdata <= {8'h00, trig_routing};
                dos_pkg::FIRST_VALUE:    rdata <= cnt[0];
                dos_pkg::SECOND_VALUE:   rdata <= cnt[1];
                dos_pkg::FIRST_MODE:     rdata <= {8'h00, mode[0]};
                dos_pkg::SECOND_MODE:    rdata <= {8'h00, mode[1]};
                dos_pkg::CLOCK_SELECT:   rdata <= {8'h00, clock_select};
                dos_pkg::OUT_POLARITY:   rdata <= {8'h00, out_polarity};
                dos_pkg::PERIPH_CLOCK:   rdata <= {8'h00, periph_clock};
                dos_pkg::IRQ_STATUS:     rdata <= {14'h0000, irq};
                default:                 rdata <= '0;
            endcase
        end
    end

    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_first_irq_set: assert property ( // [RULE_05]
        uf[0] |=> irq[0] && !run[0]
    ) else $error("first underflow did not stop and request");

    a_first_reloads: assert property ( // [RULE_05]
        $fell(run[0]) && !$past(hit(dos_pkg::FIRST_VALUE)) |-> cnt[0] == rld[0]
    ) else $error("first counter did not reload");

    a_arm_needed: assert property ( // [RULE_03]
        $rose(run[0]) && $past(mode[0][dos_pkg::TRIG_SEL_BIT])
            |-> $past(one_shot_start[dos_pkg::START_LSB])
    ) else $error("first counter started unarmed");

    a_chain_start: assert property ( // [RULE_06]
        uf[0] && trig[1] && !run[1]
            && mode[1][dos_pkg::MODE_LSB +: 2] == dos_pkg::MODE_ONE_SHOT
            |=> run[1]
    ) else $error("chained trigger missed");

    a_pulse_rise: assert property ( // [RULE_07]
        $rose(run[1]) && mode[1][dos_pkg::PULSE_BIT] && !out_polarity[1]
            |-> second_counter_pulse_pin
    ) else $error("pulse pin not high at start");

    a_pulse_fall: assert property ( // [RULE_08]
        $past(uf[1]) == 1'b0 && uf[1] && mode[1][dos_pkg::PULSE_BIT]
            && !out_polarity[1] |-> !second_counter_pulse_pin ##1 irq[1]
    ) else $error("pulse pin not low at end");

    a_idle_level: assert property ( // [RULE_21]
        !run[1] ##1 !run[1] |-> second_counter_pulse_pin == $past(out_polarity[1])
    ) else $error("idle pin not inactive");

    a_polarity: assert property ( // [RULE_09]
        run[1] && $stable(out_polarity[1]) && $stable(mode[1])
            && mode[1][dos_pkg::PULSE_BIT]
            |-> second_counter_pulse_pin == !out_polarity[1]
    ) else $error("pulse polarity wrong");

    a_base_clock: assert property ( // [RULE_13]
        periph_clock[dos_pkg::HALVE_BIT] |-> ticks[dos_pkg::T_BASE]
    ) else $error("undivided clock not selected");

    a_read_pulse: assert property (
        !$past(rd) |-> rdata == '0
    ) else $error("read data outside its cycle");
endmodule

// ### design/dos_pkg.sv
// Purpose: Shared constants of the delayed one-shot pulse block
// Assumes: Byte addresses on a 10-bit register port, 16-bit data
// Notes:   Offsets, field positions, codes and reset values
package dos_pkg;
    localparam int AW = 10;
    localparam int DW = 16;
    localparam int CW = 16;

    // Register offsets
    localparam logic [AW-1:0] ONE_SHOT_START = 10'h322;
    localparam logic [AW-1:0] TRIG_ROUTING   = 10'h323;
    localparam logic [AW-1:0] FIRST_VALUE    = 10'h326;
    localparam logic [AW-1:0] SECOND_VALUE   = 10'h328;
    localparam logic [AW-1:0] FIRST_MODE     = 10'h336;
    localparam logic [AW-1:0] SECOND_MODE    = 10'h337;
    localparam logic [AW-1:0] CLOCK_SELECT   = 10'h340;
    localparam logic [AW-1:0] OUT_POLARITY   = 10'h341;
    localparam logic [AW-1:0] PERIPH_CLOCK   = 10'h342;
    localparam logic [AW-1:0] IRQ_STATUS     = 10'h343;

    // One-shot start register field and first routing field
    localparam int START_LSB       = 0;
    localparam int FIRST_ROUTE_LSB = 6;
    // Routing register fields
    localparam int SECOND_ROUTE_LSB = 0;
    localparam logic [1:0] ROUTE_PIN   = 2'h0;
    localparam logic [1:0] ROUTE_CHAIN = 2'h2;

    // Mode register fields
    localparam int MODE_LSB     = 0;
    localparam int PULSE_BIT    = 2;
    localparam int EDGE_BIT     = 3;
    localparam int TRIG_SEL_BIT = 4;
    localparam int LEGACY_LSB   = 6;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h2;

    // Clock select field, four bits per counter
    localparam int CS_W    = 4;
    localparam int EXT_BIT = 3;
    localparam logic [2:0] CS_BASE  = 3'h0;
    localparam logic [2:0] CS_DIV8  = 3'h1;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_LOCO  = 3'h5;
    localparam logic [2:0] CS_SUB   = 3'h6;
    localparam logic [1:0] LG_BASE  = 2'h0;
    localparam logic [1:0] LG_DIV8  = 2'h1;
    localparam logic [1:0] LG_DIV32 = 2'h2;
    localparam logic [1:0] LG_SUB   = 2'h3;

    // Tick vector positions
    localparam int T_BASE = 0;
    localparam int T_D8   = 1;
    localparam int T_D32  = 2;
    localparam int T_D64  = 3;
    localparam int T_LOCO = 4;
    localparam int T_SUB  = 5;
    localparam int T_N    = 6;

    // Prescaler terminal values
    localparam logic [5:0] D8_LAST  = 6'h07;
    localparam logic [5:0] D32_LAST = 6'h1f;
    localparam logic [5:0] D64_LAST = 6'h3f;
    localparam logic [4:0] SUB_LAST = 5'h1f;

    localparam int HALVE_BIT = 0;
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// ### design/dos_chan.sv
// Purpose: One one-shot down-counter with optional pulse pin
// Assumes: trig is a one-cycle pulse and tick a per-cycle count enable in the clk domain
// Notes:   Retriggers while counting are ignored
`timescale 1ns/1ps
module dos_chan #(
    parameter int CW = dos_pkg::CW
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          tick,
    input  wire logic          trig,
    input  wire logic          enable,
    input  wire logic          load,
    input  wire logic [CW-1:0] load_data,
    input  wire logic          pulse_en,
    input  wire logic          pol_inv,
    output logic      [CW-1:0] count,
    output logic      [CW-1:0] reload,
    output logic               running,
    output logic               underflow,
    output logic               pin
);
    typedef enum logic [1:0] {
        DOS_IDLE = 2'b01,
        DOS_RUN  = 2'b10
    } dos_state_t;

    dos_state_t state;
    dos_state_t next_state;
    logic       last;

    assign last = tick && (count <= CW'(1));

    always_comb begin
        next_state = state;
        case (state)
            DOS_IDLE: begin
                if (trig && enable) begin
                    next_state = DOS_RUN;
                end
            end
            DOS_RUN: begin
                if (!enable || last) begin
                    next_state = DOS_IDLE;
                end
            end
            default: next_state = DOS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= DOS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            running <= 1'b0;
        end else begin
            running <= (next_state == DOS_RUN);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            reload <= '0;
        end else if (load) begin
            reload <= load_data;
        end
    end

    // Reload on reaching zero, then hold
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count <= '0;
        end else if (state == DOS_RUN && enable) begin
            if (last) begin
                count <= reload; // [RULE_05] [RULE_08]
            end else if (tick) begin
                count <= count - CW'(1);
            end
        end else if (load) begin
            count <= load_data;
        end else begin
            count <= reload;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            underflow <= 1'b0;
        end else begin
            underflow <= (state == DOS_RUN) && enable && last;
        end
    end

    // Active while running, inactive level when idle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin <= 1'b0;
        end else begin
            pin <= pol_inv ^ (pulse_en && next_state == DOS_RUN); // [RULE_07] [RULE_09] [RULE_21]
        end
    end
endmodule

// ### verification/dos_load.sv
// Purpose: Trigger source and pulse load beside the one-shot block
// Assumes: Trigger pin is a plain driven input of the block
// Notes:   Reports width and delay of each active pulse after a fire
`timescale 1ns/1ps
module dos_load (
    input  wire logic        clk,
    input  wire logic        fire,
    input  wire logic        pol,
    input  wire logic        pulse,
    output logic             trig,
    output logic             done,
    output logic      [31:0] width,
    output logic      [31:0] delay
);
    logic        act = 1'b0;
    logic        armed = 1'b0;
    logic [1:0]  hold = 2'h0;
    logic [31:0] wcnt = 32'h0;
    logic [31:0] dcnt = 32'h0;
    initial trig = 1'b0;
    initial done = 1'b0;
    // Rising edge held a few cycles, block pin is an input
    always @(posedge clk) begin
        hold <= fire ? 2'h3 : hold - {1'b0, hold != 2'h0};
        trig <= fire | (hold > 2'h1);
        // Retrigger during a shot keeps the first fire's delay origin
        dcnt <= (fire && !armed) ? 32'h1 : dcnt + 32'h1;
        armed <= fire | (armed & ~done);
        done <= 1'b0;
        if (armed && (pulse ^ pol)) begin
            if (!act) delay <= dcnt;
            act <= 1'b1;
            wcnt <= wcnt + 32'h1;
        end else if (act) begin
            done <= 1'b1;
            width <= wcnt;
            act <= 1'b0;
            wcnt <= 32'h0;
        end
    end
endmodule

// ### verification/tb_dos_top.sv
// Purpose: Self-checking bench of the delayed one-shot pulse block
// Assumes: Base clock ticks every cycle when undivided
// Notes:   Expected reads and pulses wait in queues for the monitor
`timescale 1ns/1ps
module tb_dos_top;
    logic [dos_pkg::AW-1:0] addr = '0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic        trig, pin1, pin2, done, fire = 1'b0, pol = 1'b0;
    logic [31:0] width, delay, cyc = 32'h0, seed = 32'h028b7ddf;
    int          bad_count = 0, check_count = 0, seen = 0, wlo, whi, dlo, dhi, d, w;
    logic [15:0] rd_q[$];
    int          pw_q[$];
    logic [9:0]  regs[7] = '{10'h322, 10'h323, 10'h326, 10'h337, 10'h340, 10'h343, 10'h300};
    logic [7:0]  cs_t[9] = '{8'h00, 8'h98, 8'ha8, 8'hb8, 8'h00, 8'h00, 8'hd8, 8'he8, 8'h00};
    logic [7:0]  pr_t[9] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    logic [1:0]  lg_t[9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h3};
    int          f_t[9] = '{2, 8, 32, 64, 8, 32, 8, 1024, 1024};

    dos_top u_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .first_counter_trigger_pin(trig), .second_counter_trigger_pin(cyc[3]),
        .subclock_in(cyc[4]), .low_speed_osc_in(cyc[2]), .first_counter_pulse_pin(pin1),
        .second_counter_pulse_pin(pin2));
    dos_load u_load (.clk(clk), .fire(fire), .pol(pol), .pulse(pin2), .trig(trig),
        .done(done), .width(width), .delay(delay));

    always #5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 32'h1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic wreg(input logic [9:0] a, input logic [15:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [9:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    task automatic pulse_once;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask

    // Zero width means no pulse may appear at all
    task automatic shot(input int wd, input int f, input int lo, input int hi, input bit re);
        int old;
        old = seen;
        if (wd > 0) begin
            wreg(dos_pkg::ONE_SHOT_START, 16'h0003);
            pw_q.push_back(f * (wd - 1) + 1);
            pw_q.push_back(f * wd);
            pw_q.push_back(lo);
            pw_q.push_back(hi);
        end
        pulse_once();
        if (re) begin
            repeat (4) @(posedge clk);
            pulse_once();
        end
        for (int i = 0; i < (wd > 0 ? 6000 : 300) && seen == old; i++) @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    // Both counters one-shot, reserved bit zero, second pulsing
    task automatic cfg(input logic [7:0] cs, input logic [7:0] pr, input logic [1:0] lg);
        wreg(dos_pkg::CLOCK_SELECT, {8'h00, cs});
        wreg(dos_pkg::PERIPH_CLOCK, {8'h00, pr});
        wreg(dos_pkg::FIRST_MODE, 16'h001a);
        wreg(dos_pkg::SECOND_MODE, {8'h00, lg, 2'h1, seed[0], 3'h6});
        seed = lfsr(seed);
    endtask

    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) chk({16'h0000, rdata}, {16'h0000, rd_q.pop_front()});
        if (done) begin
            seen++;
            if (pw_q.size() < 4) begin
                chk(32'h1, 32'h0);
            end else begin
                wlo = pw_q.pop_front();
                whi = pw_q.pop_front();
                dlo = pw_q.pop_front();
                dhi = pw_q.pop_front();
                chk({31'h0, width >= wlo && width <= whi}, 32'h1);
                chk({31'h0, delay >= dlo && delay <= dhi}, 32'h1);
                chk({31'h0, pin1}, 32'h0);
            end
        end
    end

    initial begin
        #900000;
        bad_count++;
        report_and_stop();
    end

    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        foreach (regs[i]) rreg(regs[i], 16'h0000);
        $display("reset values done");
        d = 8 + int'(seed[2:0]);
        w = 2 + int'(seed[5:4]);
        seed = lfsr(seed);
        wreg(dos_pkg::TRIG_ROUTING, 16'h0002);
        wreg(dos_pkg::FIRST_VALUE, 16'(d));
        wreg(dos_pkg::SECOND_VALUE, 16'(w));
        cfg(8'h00, 8'h01, 2'h0);
        shot(w, 1, d + 3, d + 6, 1'b1);
        rreg(dos_pkg::IRQ_STATUS, 16'h0003);
        wreg(dos_pkg::IRQ_STATUS, 16'h0003);
        rreg(dos_pkg::IRQ_STATUS, 16'h0000);
        rreg(dos_pkg::FIRST_VALUE, 16'(d));
        $display("delayed pulse done");
        wreg(dos_pkg::OUT_POLARITY, 16'h0002);
        pol <= 1'b1;
        shot(w, 1, d + 3, d + 6, 1'b0);
        wreg(dos_pkg::OUT_POLARITY, 16'h0000);
        pol <= 1'b0;
        $display("polarity done");
        d = 3 + int'(seed[1:0]);
        wreg(dos_pkg::FIRST_VALUE, 16'(d));
        foreach (f_t[i]) begin
            cfg(cs_t[i], pr_t[i], lg_t[i]);
            shot(w, f_t[i], d + 3 - i * 0, (d + 6) * (2 - int'(pr_t[i])), 1'b0);
        end
        $display("clock select done");
        cfg(8'h00, 8'h01, 2'h0);
        wreg(dos_pkg::ONE_SHOT_START, 16'h0000);
        shot(0, 1, 0, 0, 1'b0);
        wreg(dos_pkg::TRIG_ROUTING, 16'h0042);
        wreg(dos_pkg::ONE_SHOT_START, 16'h0003);
        shot(0, 1, 0, 0, 1'b0);
        $display("refusals done");
        chk(32'(pw_q.size()), 32'h0);
        chk(32'(rd_q.size()), 32'h0);
        report_and_stop();
    end
endmodule
